// ---- logic/recirc_pkg.sv ----
// Constants shared by the recirculating shift register and its controller.
// Assumes a single 200 MHz core clock on both ends of the link.
`default_nettype none
package recirc_pkg;

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_NS = 5;
   localparam int unsigned OUT_VALID_NS  = 100;
   // Longest time: round down
   localparam int unsigned OUT_VALID_CYC = OUT_VALID_NS / CLK_PERIOD_NS;
   // Phase LOW must cover output delay plus input setup
   localparam int unsigned PHASE_LOW_NS  = 150;
   localparam int unsigned PHASE_LOW_CYC = (PHASE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned PHASE_GAP_NS  = 20;
   localparam int unsigned PHASE_GAP_CYC = (PHASE_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned OUT_CNT_W     = 5;
   localparam int unsigned PHASE_CNT_W   = 6;

   // ---------------------------------------------------------------
   // Storage
   // ---------------------------------------------------------------
   localparam int unsigned REG_LENGTH    = 1024;
   localparam int unsigned HAS_CS        = 1;

   // ---------------------------------------------------------------
   // Controller register map
   // ---------------------------------------------------------------
   localparam int unsigned ADDR_W        = 4;
   localparam logic [3:0]  CTRL_OFS      = 4'h0;
   localparam logic [3:0]  TXDATA_OFS    = 4'h4;
   localparam logic [3:0]  RXDATA_OFS    = 4'h8;
   localparam logic [3:0]  COUNT_OFS     = 4'hC;
   localparam int unsigned CTRL_STORE_BIT  = 0;
   localparam int unsigned CTRL_READ_BIT   = 1;
   localparam int unsigned CTRL_SEL_BIT    = 2;
   localparam int unsigned CTRL_RETIME_BIT = 3;
   localparam int unsigned RX_DATA_BIT     = 0;
   localparam int unsigned RX_VALID_BIT    = 1;
   localparam logic [3:0]  CTRL_RST      = 4'h0;
   localparam logic [15:0] COUNT_RST     = 16'h0000;

   typedef enum logic [1:0] {
      PH_GAP_A  = 2'b00,
      PH_MASTER = 2'b01,
      PH_GAP_B  = 2'b11,
      PH_SLAVE  = 2'b10
   } phase_state_type;

endpackage : recirc_pkg
`default_nettype wire

// ---- logic/recirc_link_if.sv ----
// Link between the shift register and its controller.
// Phases idle HIGH and pulse LOW; the output line has a pull-down.
`timescale 1ns/100ps
`default_nettype none
interface recirc_link_if;
   logic phase1;
   logic phase2;
   logic data_in;
   logic store;
   logic read_gate;
   logic sel_a;
   logic sel_b;
   logic out_drv;
   logic out_oe;
   wire  out_line;

   // Open-drain: driven HIGH when enabled, pull-down otherwise
   assign out_line = out_oe ? out_drv : 1'b0;

   modport device (
      input  phase1, phase2, data_in, store, read_gate, sel_a, sel_b,
      output out_drv, out_oe
   );
   modport ctrl (
      output phase1, phase2, data_in, store, read_gate, sel_a, sel_b,
      input  out_line
   );
endinterface : recirc_link_if
`default_nettype wire

// ---- logic/phase_gen.sv ----
// Two-phase non-overlapping clock generator for the shift register.
// Assumes it runs free from reset so stored charge is always refreshed.
`timescale 1ns/100ps
`default_nettype none
module phase_gen #(
   parameter int unsigned LOW_CYC = recirc_pkg::PHASE_LOW_CYC,
   parameter int unsigned GAP_CYC = recirc_pkg::PHASE_GAP_CYC
) (
   input  wire logic core_clk_i,
   input  wire logic rst_i,
   output var  logic phase1_o,
   output var  logic phase2_o,
   output logic      any_fall_o,
   output logic      slave_last_o,
   output logic      pair_done_o
);
   localparam int unsigned W = recirc_pkg::PHASE_CNT_W;
   localparam logic [W-1:0] LOW_LAST = W'(LOW_CYC - 1);
   localparam logic [W-1:0] GAP_LAST = W'(GAP_CYC - 1);

   recirc_pkg::phase_state_type state_reg;
   recirc_pkg::phase_state_type state_next;
   logic [W-1:0]                cnt_reg;
   logic                        last;

   assign last = (state_reg == recirc_pkg::PH_MASTER || state_reg == recirc_pkg::PH_SLAVE)
                 ? (cnt_reg == LOW_LAST) : (cnt_reg == GAP_LAST);

   // Master pulse first, then slave; gaps keep the phases apart
   always_comb begin
      state_next = state_reg;
      if (last) begin
         unique case (state_reg)
            recirc_pkg::PH_GAP_A:  state_next = recirc_pkg::PH_MASTER;
            recirc_pkg::PH_MASTER: state_next = recirc_pkg::PH_GAP_B;
            recirc_pkg::PH_GAP_B:  state_next = recirc_pkg::PH_SLAVE;
            recirc_pkg::PH_SLAVE:  state_next = recirc_pkg::PH_GAP_A;
         endcase
      end
   end

   // Never stops, so no phase stays HIGH past the refresh limit
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         state_reg <= recirc_pkg::PH_GAP_A;
         cnt_reg   <= '0;
      end else begin
         state_reg <= state_next;
         cnt_reg   <= last ? '0 : cnt_reg + 1'b1;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         phase1_o <= 1'b1;
         phase2_o <= 1'b1;
      end else begin
         phase2_o <= (state_next != recirc_pkg::PH_MASTER);
         phase1_o <= (state_next != recirc_pkg::PH_SLAVE);
      end
   end

   assign any_fall_o   = last && (state_reg == recirc_pkg::PH_GAP_A ||
                                  state_reg == recirc_pkg::PH_GAP_B);
   assign slave_last_o = last && (state_reg == recirc_pkg::PH_SLAVE);
   assign pair_done_o  = slave_last_o;
endmodule : phase_gen
`default_nettype wire

// ---- logic/recirc_ctrl.sv ----
// Controller end: drives phases, store, read and selects of one register.
// Assumes software on a plain strobe port; read data one cycle later.
//
// Decided for this implementation: the register addresses and strobed register access.
`timescale 1ns/100ps
`default_nettype none
module recirc_ctrl #(
   parameter int unsigned LOW_CYC = recirc_pkg::PHASE_LOW_CYC,
   parameter int unsigned GAP_CYC = recirc_pkg::PHASE_GAP_CYC
) (
   input  wire logic                          core_clk_i,
   input  wire logic                          rst_i,
   recirc_link_if.ctrl                        link,
   input  wire logic [recirc_pkg::ADDR_W-1:0] addr_i,
   input  wire logic [31:0]                   wdata_i,
   input  wire logic                          wr_i,
   input  wire logic                          rd_i,
   output var  logic [31:0]                   rdata_o,
   output var  logic                          alt_sel_o
);
   logic        phase1;
   logic        phase2;
   logic        any_fall;
   logic        slave_last;
   logic        pair_done;
   logic [3:0]  ctrl_reg;
   logic        tx_bit_reg;
   logic        rx_bit_reg;
   logic        rx_valid_reg;
   logic [15:0] count_reg;
   logic        retime_reg;
   logic        din_reg;
   logic        read_reg;
   logic        recirc_bit;

   phase_gen #(
      .LOW_CYC(LOW_CYC),
      .GAP_CYC(GAP_CYC)
   ) u_phase (
      .core_clk_i  (core_clk_i),
      .rst_i       (rst_i),
      .phase1_o    (phase1),
      .phase2_o    (phase2),
      .any_fall_o  (any_fall),
      .slave_last_o(slave_last),
      .pair_done_o (pair_done)
   );

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         ctrl_reg   <= recirc_pkg::CTRL_RST;
         tx_bit_reg <= 1'b0;
      end else if (wr_i && addr_i == recirc_pkg::CTRL_OFS) begin
         ctrl_reg <= wdata_i[3:0];
      end else if (wr_i && addr_i == recirc_pkg::TXDATA_OFS) begin
         tx_bit_reg <= wdata_i[0];
      end
   end

   // Fresh capture wins over a read-to-clear in the same cycle
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         rx_bit_reg   <= 1'b0;
         rx_valid_reg <= 1'b0;
      end else if (slave_last && read_reg) begin
         rx_bit_reg   <= link.out_line;
         rx_valid_reg <= 1'b1;
      end else if (rd_i && addr_i == recirc_pkg::RXDATA_OFS) begin
         rx_valid_reg <= 1'b0;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         count_reg <= recirc_pkg::COUNT_RST;
      end else if (pair_done) begin
         count_reg <= count_reg + 1'b1;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         rdata_o <= 32'h0000_0000;
      end else if (rd_i) begin
         unique case (addr_i)
            recirc_pkg::CTRL_OFS:   rdata_o <= {28'h000_0000, ctrl_reg};
            recirc_pkg::TXDATA_OFS: rdata_o <= {31'h0000_0000, tx_bit_reg};
            recirc_pkg::RXDATA_OFS: rdata_o <= {30'h0000_0000, rx_valid_reg, rx_bit_reg};
            recirc_pkg::COUNT_OFS:  rdata_o <= {16'h0000, count_reg};
            default:                rdata_o <= 32'h0000_0000;
         endcase
      end else begin
         rdata_o <= 32'h0000_0000;
      end
   end

   // ---------------------------------------------------------------
   // Link
   // ---------------------------------------------------------------
   // Fast interface flop, taken at the fall of either phase
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         retime_reg <= 1'b0;
      end else if (any_fall) begin
         retime_reg <= link.out_line;
      end
   end

   assign recirc_bit = ctrl_reg[recirc_pkg::CTRL_RETIME_BIT] ? retime_reg : link.out_line;

   // External selector: new data or recirculated bit
   // One cycle of latency is covered by the long LOW time
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         din_reg <= 1'b0;
      end else begin
         din_reg <= ctrl_reg[recirc_pkg::CTRL_STORE_BIT] ? tx_bit_reg : recirc_bit;
      end
   end

   // Read changes only while phase one is HIGH
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         read_reg <= 1'b0;
      end else if (phase1) begin
         read_reg <= ctrl_reg[recirc_pkg::CTRL_READ_BIT];
      end
   end

   // Toggle on every phase pulse for a paired double-rate bank
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         alt_sel_o <= 1'b0;
      end else if (any_fall) begin
         alt_sel_o <= ~alt_sel_o;
      end
   end

   assign link.phase1    = phase1;
   assign link.phase2    = phase2;
   assign link.data_in   = din_reg;
   assign link.store     = ctrl_reg[recirc_pkg::CTRL_STORE_BIT];
   assign link.read_gate = read_reg;
   // Target chosen by chip selects on a shared output line
   assign link.sel_a     = ctrl_reg[recirc_pkg::CTRL_SEL_BIT];
   assign link.sel_b     = ctrl_reg[recirc_pkg::CTRL_SEL_BIT];
endmodule : recirc_ctrl
`default_nettype wire

// ---- logic/recirc_shift_reg.sv ----
// Recirculating two-phase serial store with open-drain output gate.
// Assumes phases, controls and selects come from logic on core_clk_i.
// Assumes the controller never pulses both phases LOW at once.
// Limitation: one chain; a double-rate bank needs two instances.
`timescale 1ns/100ps
`default_nettype none
module recirc_shift_reg #(
   parameter int unsigned LENGTH = recirc_pkg::REG_LENGTH,
   parameter int unsigned HAS_CS = recirc_pkg::HAS_CS,
   parameter int unsigned OUT_CYC = recirc_pkg::OUT_VALID_CYC
) (
   input  wire logic                      core_clk_i,
   input  wire logic                      rst_i,
   recirc_link_if.device                  link,
   output var  logic [$clog2(LENGTH)-1:0] bit_pos_o,
   output var  logic                      out_active_o
);
   localparam int unsigned PW = $clog2(LENGTH);
   localparam int unsigned CW = recirc_pkg::OUT_CNT_W;
   localparam logic [PW-1:0] LAST_POS = PW'(LENGTH - 1);
   localparam logic [CW-1:0] OUT_LAST = CW'(OUT_CYC - 1);

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   // Both phases use one edge test, so they cannot drift apart
   function automatic logic went_low(input logic was, input logic now);
      return was && !now;
   endfunction : went_low

   function automatic logic went_high(input logic was, input logic now);
      return !was && now;
   endfunction : went_high

   // Wraps at the chain length, so the length need not be a power of two
   function automatic logic [PW-1:0] next_pos(input logic [PW-1:0] pos);
      return (pos == LAST_POS) ? '0 : pos + 1'b1;
   endfunction : next_pos

   // ---------------------------------------------------------------
   // Phase edges
   // ---------------------------------------------------------------
   logic ph1_q;
   logic ph2_q;
   logic ph1_fall;
   logic ph1_rise;
   logic ph2_fall;
   logic ph2_rise;

   // Reset to the idle level so no false edge follows reset
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         ph1_q <= 1'b1;
         ph2_q <= 1'b1;
      end else begin
         ph1_q <= link.phase1;
         ph2_q <= link.phase2;
      end
   end

   assign ph1_fall = went_low(ph1_q, link.phase1);
   assign ph1_rise = went_high(ph1_q, link.phase1);
   assign ph2_fall = went_low(ph2_q, link.phase2);
   assign ph2_rise = went_high(ph2_q, link.phase2);

   // ---------------------------------------------------------------
   // Select and input gating
   // ---------------------------------------------------------------
   logic selected;
   logic din_q;
   logic take_new_q;

   // Both selects needed; variants without them are always selected
   assign selected = (HAS_CS == 0) || (link.sel_a && link.sel_b);

   // Input side only looks at its pins while phase two is LOW
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         din_q      <= 1'b0;
         take_new_q <= 1'b0;
      end else if (!link.phase2) begin
         din_q      <= link.data_in;
         // Store LOW or a select LOW means recirculate
         take_new_q <= selected && link.store;
      end
   end

   // ---------------------------------------------------------------
   // Storage ring
   // ---------------------------------------------------------------
   // A pointer over a flop array stands in for moving every bit;
   // mem[ptr] is always the last bit of the chain.
   logic [LENGTH-1:0] mem_reg;
   logic [PW-1:0]     ptr_reg;
   logic              master_reg;
   logic              master_full_reg;
   logic              last_bit;

   assign last_bit = mem_reg[ptr_reg];

   // Master stage: value present just before phase two returns HIGH
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         master_reg      <= 1'b0;
         master_full_reg <= 1'b0;
      end else if (ph2_rise) begin
         // New data into the first bit on the master pulse
         master_reg      <= take_new_q ? din_q : last_bit;
         master_full_reg <= 1'b1;
      end else if (ph1_rise) begin
         master_full_reg <= 1'b0;
      end
   end

   // Clearing the ring on reset only keeps runs repeatable
   // One position per full master/slave pair, never on a lone pulse
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         mem_reg <= '0;
         ptr_reg <= '0;
      end else if (ph1_rise && master_full_reg) begin
         mem_reg[ptr_reg] <= master_reg;
         ptr_reg          <= next_pos(ptr_reg);
      end
   end

   // ---------------------------------------------------------------
   // Output stage
   // ---------------------------------------------------------------
   logic          out_bit_reg;
   logic          gate_now;
   logic [CW-1:0] cnt_reg;
   logic          on_reg;
   logic          hold_reg;

   // Chain output moves only at a falling phase edge
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         out_bit_reg <= 1'b0;
      end else if (ph1_fall || ph2_fall) begin
         out_bit_reg <= last_bit;
      end
   end

   // Read and select are taken live; the controller must hold them
   // Output gate works only while phase one is LOW
   assign gate_now = !link.phase1 && link.read_gate && selected;

   // Delay from gate opening to valid data
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         cnt_reg <= '0;
      end else if (!gate_now) begin
         cnt_reg <= '0;
      end else if (cnt_reg != OUT_LAST) begin
         cnt_reg <= cnt_reg + 1'b1;
      end
   end

   // Until the count expires the previous bit is still shown
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         on_reg   <= 1'b0;
         hold_reg <= 1'b0;
      end else if (gate_now && cnt_reg == OUT_LAST) begin
         on_reg   <= 1'b1;
         hold_reg <= out_bit_reg;
      end else if (!link.phase1 && !gate_now) begin
         // Read or select gone before phase one rises: off
         on_reg <= 1'b0;
      end
      // With phase one HIGH the value stays stored
   end

   // Open-drain AND: pull HIGH only for a stored one
   assign link.out_drv = 1'b1;
   assign link.out_oe  = on_reg && hold_reg;

   // ---------------------------------------------------------------
   // Status
   // ---------------------------------------------------------------
   assign bit_pos_o    = ptr_reg;
   assign out_active_o = on_reg;
endmodule : recirc_shift_reg
`default_nettype wire

// ---- verif/recirc_link_assertions.sv ----
// Concurrent checks on the link between the shift register and its controller.
// Assumes instantiation beside the link interface, on the single core clock.
`timescale 1ns/100ps
`default_nettype none
module recirc_link_assertions #(
   parameter int LOW_CYC = recirc_pkg::PHASE_LOW_CYC,
   parameter int GAP_CYC = recirc_pkg::PHASE_GAP_CYC,
   parameter int OUT_CYC = recirc_pkg::OUT_VALID_CYC
) (
   input wire logic core_clk_i,
   input wire logic rst_i,
   input wire logic phase1,
   input wire logic phase2,
   input wire logic read_gate,
   input wire logic sel_a,
   input wire logic sel_b,
   input wire logic out_drv,
   input wire logic out_oe,
   input wire logic out_line
);
   logic [7:0] low_cnt_reg;
   logic [7:0] high_cnt_reg;
   logic       gate_on;

   assign gate_on = read_gate && sel_a && sel_b;

   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (rst_i);

   // ---------------------------------------------------------------
   // Pulse length counters
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk_i) begin
      if (rst_i || (phase1 && phase2))
         low_cnt_reg <= 8'h00;
      else
         low_cnt_reg <= low_cnt_reg + 8'h01;
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i || !phase1 || !phase2)
         high_cnt_reg <= 8'h00;
      else
         high_cnt_reg <= high_cnt_reg + 8'h01;
   end

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   chk_phase_overlap: assert property (phase1 || phase2)
      else $error("both phases low together");
   chk_low_length: assert property ((phase1 && phase2 && (!$past(phase1) || !$past(phase2))) |->
      low_cnt_reg == LOW_CYC) else $error("phase low time wrong");
   chk_gap_bound: assert property (high_cnt_reg <= GAP_CYC)
      else $error("clocks stopped high too long");
   chk_master_first: assert property ($fell(phase1) |->
      $past(phase2, 1) && !$past(phase2, GAP_CYC + 1)) else $error("slave pulse without master");
   chk_oe_cause: assert property ($rose(out_oe) |-> $past(gate_on) && !phase1)
      else $error("output enabled without read and select");
   chk_oe_latency: assert property ($rose(out_oe) |->
      !$past(phase1, OUT_CYC) && $past(phase1, OUT_CYC + 1)) else $error("output latency wrong");
   chk_oe_turn_off: assert property ((!phase1 && !gate_on) |=> !out_oe)
      else $error("output not turned off");
   chk_oe_moves: assert property ($changed(out_oe) |-> !$past(phase1))
      else $error("output changed outside phase one low");
   chk_drive_high: assert property (out_oe |-> out_drv && out_line)
      else $error("open drain output not high");

   cov_out_on: cover property ($rose(out_oe));
   cov_out_held: cover property (phase1 && out_oe);
   cov_out_off: cover property ($fell(out_oe));
endmodule : recirc_link_assertions
`default_nettype wire

// ---- verif/testbench.sv ----
// Self-checking bench: controller and shift register joined by the link.
// Assumes software access through the controller's strobe port only.
`timescale 1ns/100ps
`default_nettype none
`define CHECK(got, exp) \
   begin \
      total_checks++; \
      if ((got) !== (exp)) begin \
         errors++; \
         $display("[FAIL] t=%0t got=%0h exp=%0h", $time, (got), (exp)); \
      end \
   end
module testbench;
   // Short phases keep four revolutions of the ring, plus 100 pairs, well inside the run
   localparam int LEN  = 512;
   localparam int LOW  = 12;
   localparam int GAP  = 1;
   localparam int OUTC = 4;
   logic        core_clk_i = 1'b0;
   logic        rst_i      = 1'b1;
   logic [3:0]  addr_i     = 4'h0;
   logic [31:0] wdata_i    = 32'h00000000;
   logic        wr_i       = 1'b0;
   logic        rd_i       = 1'b0;
   logic [31:0] rdata_o;
   logic        alt_sel_o;
   logic [8:0]  bit_pos_o;
   logic        out_active_o;
   int          errors       = 0;
   int          total_checks = 0;
   int          cycles       = 0;
   int          seed         = 48;
   int          k            = 0;
   int          fall_cnt     = 0;
   logic        slot [LEN];
   logic        nslot [LEN];
   logic        rxb [LEN];
   logic [3:0]  prev_ctrl = 4'h0;

   recirc_link_if link ();
   recirc_ctrl #(.LOW_CYC(LOW), .GAP_CYC(GAP)) recirc_ctrl_inst (
      .core_clk_i(core_clk_i), .rst_i(rst_i), .link(link), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .alt_sel_o(alt_sel_o));
   recirc_shift_reg #(.LENGTH(LEN), .HAS_CS(1), .OUT_CYC(OUTC)) recirc_shift_reg_inst (
      .core_clk_i(core_clk_i), .rst_i(rst_i), .link(link), .bit_pos_o(bit_pos_o),
      .out_active_o(out_active_o));
   recirc_link_assertions #(.LOW_CYC(LOW), .GAP_CYC(GAP), .OUT_CYC(OUTC)) chk_inst (
      .core_clk_i(core_clk_i), .rst_i(rst_i), .phase1(link.phase1), .phase2(link.phase2),
      .read_gate(link.read_gate), .sel_a(link.sel_a), .sel_b(link.sel_b),
      .out_drv(link.out_drv), .out_oe(link.out_oe), .out_line(link.out_line));

   // ---------------------------------------------------------------
   // Clock, timeout and verdict
   // ---------------------------------------------------------------
   always #2.5 core_clk_i = ~core_clk_i;

   always @(posedge core_clk_i) begin
      cycles++;
      if (cycles == 70000) begin
         errors++;
         give_verdict();
      end
   end

   // Phase falls since reset; the bank toggle must follow their parity
   always @(negedge link.phase1 or negedge link.phase2) fall_cnt++;

   task automatic give_verdict;
      $display("checks=%0d errors=%0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : give_verdict

   // ---------------------------------------------------------------
   // Register port and pair helpers
   // ---------------------------------------------------------------
   function automatic logic rbit();
      logic [31:0] r;
      r = $random(seed);
      return r[0];
   endfunction : rbit

   // Bit expected back from the ring, n shifts after the fill reference
   function automatic logic ring_at(input int n);
      return slot[(n + k) % LEN];
   endfunction : ring_at

   task automatic wr(input logic [3:0] a, input logic [31:0] v);
      addr_i  <= a;
      wdata_i <= v;
      wr_i    <= 1'b1;
      @(posedge core_clk_i);
      wr_i <= 1'b0;
      @(posedge core_clk_i);
   endtask : wr

   task automatic rd(input logic [3:0] a, output logic [31:0] v);
      addr_i <= a;
      rd_i   <= 1'b1;
      @(posedge core_clk_i);
      rd_i <= 1'b0;
      @(posedge core_clk_i);
      v = rdata_o;
   endtask : rd

   // One shift: read back the bit just captured, then set up the next pair
   task automatic pair(input logic [3:0] ctrl, input logic tx, output logic [1:0] got);
      logic [31:0] v;
      @(posedge link.phase1);
      @(posedge core_clk_i);
      rd(recirc_pkg::RXDATA_OFS, v);
      got = v[1:0];
      if (prev_ctrl[1]) `CHECK(v[1], 1'b1)
      wr(recirc_pkg::CTRL_OFS, {28'h0000000, ctrl});
      wr(recirc_pkg::TXDATA_OFS, {31'h00000000, tx});
      prev_ctrl = ctrl;
   endtask : pair

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      logic [31:0] v;
      logic [1:0]  got;
      logic [3:0]  c;
      logic [15:0] last_cnt;
      logic [8:0]  last_pos;
      logic        ok;
      int          j;
      int          i;
      repeat (3) @(posedge core_clk_i);
      rst_i <= 1'b0;
      @(posedge core_clk_i);
      rd(recirc_pkg::CTRL_OFS, v);
      `CHECK(v, 32'h00000000)
      rd(recirc_pkg::COUNT_OFS, v);
      `CHECK(v, 32'h00000000)
      wr(4'h2, 32'hFFFFFFFF);
      rd(4'h2, v);
      `CHECK(v, 32'h00000000)
      // Fill the whole ring with random bits
      for (j = 0; j < LEN; j++) begin
         slot[j] = rbit();
         pair(4'h5, slot[j], got);
      end
      // Recirculate one revolution; some rotation must match
      for (j = 0; j < LEN; j++) begin
         pair(4'h6, rbit(), got);
         rxb[j] = got[0];
         rd(recirc_pkg::COUNT_OFS, v);
         #1;
         if (j > 0) `CHECK(v[15:0] - last_cnt, 16'h0001)
         if (j > 0) `CHECK(bit_pos_o - last_pos, 9'h001)
         `CHECK(alt_sel_o, fall_cnt[0])
         last_cnt = v[15:0];
         last_pos = bit_pos_o;
      end
      ok = 1'b0;
      for (k = 0; k < LEN && !ok; k++) begin
         ok = 1'b1;
         for (i = 1; i < LEN; i++)
            if (rxb[i] !== slot[(i + k) % LEN]) ok = 1'b0;
      end
      k--;
      `CHECK(ok, 1'b1)
      // Random mix of updates and recirculation, with retime toggled
      for (j = 0; j < LEN; j++) begin
         c = {rbit(), 3'b110};
         nslot[j] = slot[j];
         if (rbit()) begin
            c[0] = 1'b1;
            nslot[j] = rbit();
         end
         pair(c, nslot[j], got);
         `CHECK(got[0], ring_at(j))
         `CHECK(out_active_o, 1'b1)
      end
      for (j = 0; j < LEN; j++)
         slot[j] = nslot[j];
      // Deselected: store and read requested, line must stay low
      for (j = 0; j < 100; j++) begin
         pair(4'h3, rbit(), got);
         if (j > 0) `CHECK(got, 2'b10)
         if (j > 0) `CHECK(out_active_o, 1'b0)
      end
      // Contents must be untouched by the deselected stores
      for (j = 0; j < LEN; j++) begin
         pair(4'h6, 1'b1, got);
         if (j > 0) `CHECK(got[0], ring_at(j + 100))
      end
      give_verdict();
   end
endmodule : testbench
`default_nettype wire
